//--- core/mps_pkg.sv
// shared constants for the mirror pulse sequencer ends
// assumes a single 100 MHz clock shared by both ends
package mps_pkg;
    localparam int CLK_PERIOD_NS   = 10;
    localparam int BLOCKS          = 16;
    localparam int IDX_W           = 4;
    localparam int SPAN_W          = 2;
    // load and settle figures, in ns except the row load, which is in ps
    localparam int ROW_LOAD_PS     = 37090;
    localparam int BLOCK_LOAD_NS   = 5040;
    localparam int SETTLE_NS       = 4000;
    // cycle counts, least times rounded up
    localparam int SETTLE_CYC      =
        (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLOCK_LOAD_CYC  =
        (BLOCK_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC       = 2;
    localparam int RESET_WAVE_CYC  = 16;
    localparam int HOLD_CYC        = 2;
    localparam int CNT_W           = 16;
    localparam logic [1:0] SPAN_SINGLE = 2'h0;
    localparam logic [1:0] SPAN_DUAL   = 2'h1;
    localparam logic [1:0] SPAN_QUAD   = 2'h2;
    localparam logic [1:0] SPAN_GLOBAL = 2'h3;
    localparam logic [15:0] MASK_NONE  = 16'h0000;
    localparam logic [15:0] MASK_ONE   = 16'h0001;
    localparam logic [15:0] MASK_TWO   = 16'h0003;
    localparam logic [15:0] MASK_FOUR  = 16'h000f;
    localparam logic [15:0] MASK_ALL   = 16'hffff;
    localparam logic [3:0]  IDX_ZERO   = 4'h0;
endpackage

//--- core/mps_if.sv
// link between the user logic end and the pulse sequencer end
// assumes both ends run on ref_clk
`timescale 1ns/1ps
interface mps_if;
    logic [1:0] block_span_select;
    logic [3:0] block_index_select;
    logic       mirror_pulse_request;
    logic       mirror_pulse_in_progress;
    logic       load_request;
    logic       clear_request;
    logic [3:0] load_block;
    logic       load_accept;
    logic       init_done;
    modport dev (
        input  block_span_select,
        input  block_index_select,
        input  mirror_pulse_request,
        output mirror_pulse_in_progress,
        input  load_request,
        input  clear_request,
        input  load_block,
        output load_accept,
        output init_done
    );
    modport usr (
        output block_span_select,
        output block_index_select,
        output mirror_pulse_request,
        input  mirror_pulse_in_progress,
        output load_request,
        output clear_request,
        output load_block,
        input  load_accept,
        input  init_done
    );
endinterface

//--- core/mps_device.sv
// pulse sequencer end: issues mirror clocking pulses, guards loads
// assumes link inputs come from logic on the same ref_clk
// assumes the user end paces requests by the in-progress flag
`timescale 1ns/1ps
module mps_device #(
    parameter int SETTLE_CYCLES = mps_pkg::SETTLE_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    mps_if.dev               lnk,
    output logic [15:0]      mirror_state_update,
    output logic [15:0]      pulsing_blocks,
    output logic             pulse_reset_wave
);
    typedef enum logic [1:0] {
        MPS_IDLE, MPS_SETUP, MPS_WAVE, MPS_HOLD
    } mps_state_e;

    // ---------------------------------------------
    // selection decode
    // ---------------------------------------------
    // dual and quad bases drop the low index bits to their group start
    logic [15:0] sel_mask;
    logic [3:0]  base;
    always_comb begin
        base = lnk.block_index_select;
        sel_mask = mps_pkg::MASK_NONE;
        case (lnk.block_span_select)
            mps_pkg::SPAN_SINGLE: begin
                sel_mask = mps_pkg::MASK_ONE << base;
            end
            mps_pkg::SPAN_DUAL: begin
                base = {lnk.block_index_select[3:1], 1'b0};
                sel_mask = mps_pkg::MASK_TWO << base;
            end
            mps_pkg::SPAN_QUAD: begin
                base = {lnk.block_index_select[3:2], 2'b00};
                sel_mask = mps_pkg::MASK_FOUR << base;
            end
            default: begin
                base = mps_pkg::IDX_ZERO;
                sel_mask = mps_pkg::MASK_ALL;
            end
        endcase
    end

    // ---------------------------------------------
    // pulse sequencer
    // ---------------------------------------------
    localparam logic [mps_pkg::CNT_W-1:0] CNT_STEP = mps_pkg::CNT_W'(1);

    mps_state_e                state;
    mps_state_e                next_state;
    logic [mps_pkg::CNT_W-1:0] cnt;
    logic [mps_pkg::CNT_W-1:0] next_cnt;
    logic [15:0]               target;
    logic                      req_q;
    logic                      req_rise;
    logic                      busy;
    logic                      phase_end;
    logic                      take;

    // a request held high never restarts a pulse: only its rise counts
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            req_q <= 1'b0;
        end else begin
            req_q <= lnk.mirror_pulse_request;
        end
    end

    assign req_rise  = lnk.mirror_pulse_request & ~req_q;
    assign busy      = (state != MPS_IDLE);
    assign phase_end = (cnt == '0);
    // a rise while busy is dropped, not queued for later
    assign take      = req_rise & ~busy;

    // same phase lengths whatever the span, so duration never varies
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            MPS_IDLE: begin
                if (take) begin
                    next_cnt   = mps_pkg::CNT_W'(mps_pkg::SETUP_CYC - 1);
                    next_state = MPS_SETUP;
                end
            end
            MPS_SETUP: begin
                if (phase_end) begin
                    next_cnt   = mps_pkg::CNT_W'(mps_pkg::RESET_WAVE_CYC - 1);
                    next_state = MPS_WAVE;
                end else begin
                    next_cnt = cnt - CNT_STEP;
                end
            end
            MPS_WAVE: begin
                if (phase_end) begin
                    next_cnt   = mps_pkg::CNT_W'(SETTLE_CYCLES
                                 + mps_pkg::HOLD_CYC - 1);
                    next_state = MPS_HOLD;
                end else begin
                    next_cnt = cnt - CNT_STEP;
                end
            end
            MPS_HOLD: begin
                if (phase_end) begin
                    next_state = MPS_IDLE;
                end else begin
                    next_cnt = cnt - CNT_STEP;
                end
            end
            default: begin
                next_state = MPS_IDLE;
                next_cnt   = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state <= MPS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // counts down per phase; zero marks the phase end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    // selects are sampled once, so a later change cannot move a live pulse
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            target <= mps_pkg::MASK_NONE;
        end else if (take) begin
            target <= sel_mask;
        end else if (state == MPS_HOLD && phase_end) begin
            target <= mps_pkg::MASK_NONE;
        end
    end

    // ---------------------------------------------
    // outputs
    // ---------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            mirror_state_update <= mps_pkg::MASK_NONE;
        end else if (state == MPS_WAVE && phase_end) begin
            // mirrors take the loaded data only here, never on load
            mirror_state_update <= target;
        end else begin
            mirror_state_update <= mps_pkg::MASK_NONE;
        end
    end

    // registered from the next state so it lines up with the wave phase
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pulse_reset_wave <= 1'b0;
        end else begin
            pulse_reset_wave <= (next_state == MPS_WAVE);
        end
    end

    assign lnk.mirror_pulse_in_progress = busy;
    assign pulsing_blocks = target;

    // ---------------------------------------------
    // load guard
    // ---------------------------------------------
    // combinational, so a held request passes the cycle its block frees
    // loads to idle blocks pass even mid-pulse
    assign lnk.load_accept = (lnk.load_request | lnk.clear_request)
        & ~target[lnk.load_block];

    // ---------------------------------------------
    // init flag
    // ---------------------------------------------
    // init completes one cycle after reset release
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            lnk.init_done <= 1'b0;
        end else begin
            lnk.init_done <= 1'b1;
        end
    end
endmodule

//--- core/mps_user.sv
// user logic end: drives span, index and pulse requests, loads
// assumes the sequencer end shares ref_clk
`timescale 1ns/1ps
module mps_user (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    mps_if.usr               lnk,
    input  wire logic [1:0]  cfg_span,
    input  wire logic [3:0]  cmd_index,
    input  wire logic        cmd_pulse,
    input  wire logic        cmd_load,
    input  wire logic        cmd_clear,
    input  wire logic [3:0]  cmd_block,
    output logic             cmd_pulse_ready,
    output logic             cmd_load_done,
    output logic             ready
);
    logic [1:0] span_q;
    logic       span_taken;

    // span latched once after reset; later changes need a restart
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            span_q     <= mps_pkg::SPAN_SINGLE;
            span_taken <= 1'b0;
        end else if (!span_taken) begin
            span_q     <= cfg_span;
            span_taken <= 1'b1;
        end
    end

    // ---------------------------------------------
    // pulse request
    // ---------------------------------------------
    logic [3:0] index_q;
    logic       req;
    assign cmd_pulse_ready = ~lnk.mirror_pulse_in_progress & ~req
        & lnk.init_done;
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            index_q <= mps_pkg::IDX_ZERO;
            req     <= 1'b0;
        end else if (req) begin
            req <= 1'b0;
        end else if (cmd_pulse && cmd_pulse_ready) begin
            index_q <= cmd_index;
            req     <= 1'b1;
        end
    end
    // selects settle one cycle before the request rises
    assign lnk.block_span_select  = span_q;
    assign lnk.block_index_select = (cmd_pulse && cmd_pulse_ready)
        ? cmd_index : index_q;
    assign lnk.mirror_pulse_request = req;

    // ---------------------------------------------
    // load and clear: held until the sequencer accepts
    // ---------------------------------------------
    assign lnk.load_request  = cmd_load & lnk.init_done;
    assign lnk.clear_request = cmd_clear & lnk.init_done;
    assign lnk.load_block    = cmd_block;
    assign cmd_load_done     = lnk.load_accept;
    assign ready             = lnk.init_done;
endmodule

//--- testbench/mps_properties.sv
// link checker: pulse timing and load guard seen on the link
// assumes one ref_clk domain and nrst synchronous active low
`timescale 1ns/1ps
module mps_properties #(
    parameter int SETTLE_CYCLES = mps_pkg::SETTLE_CYC
) (
    input wire logic       ref_clk,
    input wire logic       nrst,
    input wire logic [1:0] block_span_select,
    input wire logic [3:0] block_index_select,
    input wire logic       mirror_pulse_request,
    input wire logic       mirror_pulse_in_progress,
    input wire logic       load_request,
    input wire logic       clear_request,
    input wire logic [3:0] load_block,
    input wire logic       load_accept,
    input wire logic       init_done
);
    localparam int DUR = mps_pkg::SETUP_CYC + mps_pkg::RESET_WAVE_CYC
        + SETTLE_CYCLES + mps_pkg::HOLD_CYC;
    wire         req  = mirror_pulse_request;
    wire         busy = mirror_pulse_in_progress;
    wire  [3:0]  idx  = block_index_select;
    logic [15:0] cnt;
    logic [15:0] m;
    // --------------------------------
    // helper state and assertions
    // --------------------------------
    // the link carries no mask, so it is rebuilt from the selects
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            m <= 16'h0000;
        end else if ($rose(req) && !busy) begin
            case (block_span_select)
                2'h0: m <= 16'h0001 << idx;
                2'h1: m <= 16'h0003 << {idx[3:1], 1'b0};
                2'h2: m <= 16'h000f << {idx[3:2], 2'b00};
                default: m <= 16'hffff;
            endcase
        end
    end
    always_ff @(posedge ref_clk) begin
        cnt <= (!nrst || !busy) ? 16'h0000 : cnt + 16'h0001;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_pulse_start: assert property ($rose(req) && !busy |=> busy)
        else $error("pulse request not taken");
    a_pulse_time: assert property (
        $fell(busy) |-> cnt == 16'(DUR))
        else $error("pulse length wrong");
    a_busy_hold: assert property (busy |-> cnt < 16'(DUR))
        else $error("busy held too long");
    a_busy_cause: assert property ($rose(busy) |-> $past(req))
        else $error("busy without request");
    a_init_up: assert property ($past(nrst) |-> init_done)
        else $error("init done missing");
    a_req_pulse: assert property (req |=> !req)
        else $error("request longer than one cycle");
    a_user_wait: assert property ($rose(req) |-> !busy)
        else $error("request while busy");
    a_load_guard: assert property (
        (load_request || clear_request) |->
        load_accept == !(busy && m[load_block]))
        else $error("load guard wrong");
    c_quad: cover property ($rose(req) && block_span_select == 2'h2);
    c_refuse: cover property (clear_request && !load_accept);
    c_done: cover property ($fell(busy));
endmodule

//--- testbench/test_mirror_pulse_sequencer.sv
// bench: user end and sequencer end joined by the link, model compared
// assumes core modules, link and checker compiled before this file
`timescale 1ns/1ps
module test_mirror_pulse_sequencer;
    // short settle keeps each pulse at a few tens of cycles
    localparam int S   = 8;
    localparam int DUR = mps_pkg::SETUP_CYC + mps_pkg::RESET_WAVE_CYC
        + S + mps_pkg::HOLD_CYC;
    logic        ref_clk, nrst, cmd_pulse, cmd_load, cmd_clear;
    logic [1:0]  cfg_span;
    logic [3:0]  cmd_index, cmd_block;
    logic        cmd_pulse_ready, cmd_load_done, ready;
    logic [15:0] ups, pb;
    logic        wave;
    int          err_count, total_checks, run, idx, base, wave_run;
    int          exp_q[$];
    mps_if lnk_i ();
    mps_device #(.SETTLE_CYCLES(S)) i_mps_device (.ref_clk, .nrst,
        .lnk(lnk_i), .mirror_state_update(ups), .pulsing_blocks(pb),
        .pulse_reset_wave(wave));
    mps_user i_mps_user (.ref_clk, .nrst, .lnk(lnk_i), .cfg_span,
        .cmd_index, .cmd_pulse, .cmd_load, .cmd_clear, .cmd_block,
        .cmd_pulse_ready, .cmd_load_done, .ready);
    mps_properties #(.SETTLE_CYCLES(S)) i_mps_properties (.ref_clk, .nrst,
        .block_span_select(lnk_i.block_span_select),
        .block_index_select(lnk_i.block_index_select),
        .mirror_pulse_request(lnk_i.mirror_pulse_request),
        .mirror_pulse_in_progress(lnk_i.mirror_pulse_in_progress),
        .load_request(lnk_i.load_request),
        .clear_request(lnk_i.clear_request),
        .load_block(lnk_i.load_block), .load_accept(lnk_i.load_accept),
        .init_done(lnk_i.init_done));
    always #5 ref_clk = ~ref_clk;
    // --------------------------------
    // model, checks and drivers
    // --------------------------------
    function automatic int model_mask(input int span, input int ix);
        int w;
        w = (span == 3) ? 16 : (1 << span);
        return (((1 << w) - 1) << (ix & ~(w - 1))) & 32'h0000_ffff;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        total_checks++;
        if (got !== want) begin
            err_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic close_out();
        if (err_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic give_up();
        err_count++;
        close_out();
    endtask
    // idle also waits for the model queue, so a queued pulse is not missed
    task automatic wait_for(input logic want);
        for (int n = 0; n < 300; n++) begin
            @(posedge ref_clk);
            if (lnk_i.mirror_pulse_in_progress === want &&
                (want || exp_q.size() == 0)) return;
            if (n == 299) give_up();
        end
    endtask
    task automatic do_reset(input int span, input int len);
        @(negedge ref_clk);
        nrst     = 1'b0;
        cfg_span = 2'(span);
        repeat (len) @(negedge ref_clk);
        nrst = 1'b1;
        for (int n = 0; n < 300; n++) begin
            @(posedge ref_clk);
            if (ready === 1'b1) break;
            if (n == 299) give_up();
        end
    endtask
    task automatic pulse(input int ix);
        @(negedge ref_clk);
        cmd_index = 4'(ix);
        cmd_pulse = 1'b1;
        exp_q.push_back(model_mask(cfg_span, ix));
        for (int n = 0; n < 300; n++) begin
            @(posedge ref_clk);
            if (cmd_pulse_ready === 1'b1) break;
            if (n == 299) give_up();
        end
        @(negedge ref_clk);
        cmd_pulse = 1'b0;
    endtask
    task automatic access(input int blk, input logic clr, input logic want);
        logic b;
        @(negedge ref_clk);
        cmd_block = 4'(blk);
        cmd_load  = !clr;
        cmd_clear = clr;
        for (int n = 0; n < 300; n++) begin
            @(posedge ref_clk);
            b = lnk_i.mirror_pulse_in_progress;
            if (cmd_load_done === 1'b1) break;
            if (n == 299) give_up();
        end
        @(negedge ref_clk);
        cmd_load  = 1'b0;
        cmd_clear = 1'b0;
        check(b, want);
    endtask
    always @(posedge ref_clk) begin
        if (nrst === 1'b1 && ups !== 16'h0000)
            check(ups, exp_q.size() ? exp_q.pop_front() : 0);
        if (nrst !== 1'b1) begin
            run = 0;
            wave_run = 0;
        end else if (lnk_i.mirror_pulse_in_progress === 1'b1) begin
            run++;
            if (wave === 1'b1) wave_run++;
        end else if (run != 0) begin
            check(run, DUR);
            check(wave_run, mps_pkg::RESET_WAVE_CYC);
            run = 0;
            wave_run = 0;
        end
    end
    initial begin
        ref_clk = 1'b0;
        {nrst, cmd_pulse, cmd_load, cmd_clear} = 4'h0;
        {cfg_span, cmd_index, cmd_block} = 10'h000;
        void'($urandom(22));
        for (int s = 0; s < 4; s++) begin
            do_reset(s, (s == 0) ? 20 : 4);
            idx  = $urandom % 16;
            base = (s == 3) ? 0 : idx & ~((1 << s) - 1);
            pulse(idx);
            wait_for(1'b1);
            check(pb, model_mask(s, idx));
            if (s != 3) access((base + 4) % 16, 1'b0, 1'b1);
            access(base + $urandom % ((s == 3) ? 16 : (1 << s)),
                   1'b1, 1'b0);
            pulse($urandom % 16);
            pulse($urandom % 16);
            wait_for(1'b0);
        end
        close_out();
    end
endmodule
